// ==== inc/ser_pkg.sv ====
// package: constants and types for the system-error report enable block
// Summary of operation
// - six enable bits, one per error condition
// - report errors as hub special-cycle messages
// - message also needs global command enable
// - one message per pending condition; repeats before it is sent merge into it
// - lock to non-DRAM reported only when enabled
// - lock report needs cmd bit 8, sets status 14
// - target abort sets status 12, report sets 14
`default_nettype none
package ser_pkg;
   localparam int SER_NUM_SRC = 6;
   localparam logic [7:0] SER_EN_OFFSET = 8'hcb;
   localparam logic [7:0] SER_EN_RESET = 8'h00;
   localparam logic [1:0] SER_RSVD_READ = 2'h0;
   // enable and event bit positions
   localparam int SER_BIT_REFRESH = 5;
   localparam int SER_BIT_TABORT = 4;
   localparam int SER_BIT_LOCK = 3;
   localparam int SER_BIT_OUTSIDE = 2;
   localparam int SER_BIT_INVALID = 1;
   localparam int SER_BIT_BADXLAT = 0;
   // fields of the pci command and status registers outside this block
   localparam int SER_CMD_SERR_EN_BIT = 8;
   localparam int SER_STS_SIG_SERR_BIT = 14;
   localparam int SER_STS_RCV_TABORT_BIT = 12;
   localparam logic [2:0] SER_SRC_RESET = 3'h0;
   typedef logic [SER_NUM_SRC-1:0] ser_vec_t;
endpackage
`default_nettype wire

// ==== inc/ser_pend_if.sv ====
// interface: pending error conditions between the register side and sender
`default_nettype none
interface ser_pend_if;
   import ser_pkg::*;
   ser_vec_t pend;
   ser_vec_t clr;
   modport owner (output pend, input clr);
   modport sender (input pend, output clr);
endinterface
`default_nettype wire

// ==== rtl/ser_msg_sender.sv ====
// module: issues one hub system-error special cycle per pending condition
`default_nettype none
module ser_msg_sender
   import ser_pkg::*;
(
   input wire logic clk,           // core clock
   input wire logic rst,           // synchronous reset
   ser_pend_if.sender pif,         // pending set / clear
   output logic msg_valid,         // special-cycle request
   output logic [2:0] msg_src,     // condition being reported
   input wire logic msg_ready      // hub accepts the message
);
   import ser_pkg::*;

   typedef struct packed {
      logic busy;
      logic [2:0] src;
   } ser_snd_t;

   ser_snd_t st;
   ser_snd_t next_st;
   logic fire;

   assign fire = st.busy && msg_ready;
   assign msg_valid = st.busy;
   assign msg_src = st.src;

   always_comb begin
      next_st = st;
      pif.clr = '0;
      if (fire) begin
         // clear exactly the one condition whose message went out
         pif.clr[st.src] = 1'b1;
         next_st.busy = 1'b0;
      end else if (!st.busy && |pif.pend) begin
         // lowest bit first; others wait, none is dropped
         for (int i = SER_NUM_SRC - 1; i >= 0; i--) begin
            if (pif.pend[i]) begin
               next_st.src = 3'(i);
            end
         end
         next_st.busy = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '{busy: 1'b0, src: SER_SRC_RESET};
      end else begin
         st <= next_st;
      end
   end

   a_msg_holds: assert property (@(posedge clk) disable iff (rst)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_src))
      else $error("message dropped before the hub took it");
   a_one_per_err: assert property (@(posedge clk) disable iff (rst)
      fire |=> !msg_valid ##1 !pif.pend[$past(msg_src, 2)] || msg_valid)
      else $error("condition reported twice for one occurrence");
endmodule // ser_msg_sender
`default_nettype wire

// ==== rtl/ser_top.sv ====
// module: system-error report enable register and message gating
`default_nettype none
module ser_top
   import ser_pkg::*;
(
   input wire logic clk,                 // core clock, 100 MHz
   input wire logic rst,                 // synchronous reset, active high
   input wire logic cfg_wr,              // config write strobe
   input wire logic cfg_rd,              // config read strobe
   input wire logic [7:0] cfg_addr,      // config byte offset
   input wire logic [7:0] cfg_wdata,     // config write data
   output logic [7:0] cfg_rdata,         // config read data, next cycle
   input wire logic agp_mode,            // device runs in agp mode
   input wire logic [15:0] pci_command,  // pci command register value
   input wire ser_vec_t err_event,       // one-cycle detector pulses
   output logic msg_valid,               // hub serr special cycle request
   output logic [2:0] msg_src,           // condition of that message
   input wire logic msg_ready,           // hub interface takes message
   output logic sts_sig_serr_set,        // pulse: set status bit 14
   output logic sts_rcv_tabort_set       // pulse: set status bit 12
);
   import ser_pkg::*;

   typedef struct packed {
      logic [7:0] en;
      ser_vec_t pend;
      logic [7:0] rdata;
      logic sig_serr;
      logic rcv_tabort;
   } ser_state_t;

   ser_state_t st;
   ser_state_t next_st;
   ser_vec_t report;
   logic global_en;
   logic en_hit;

   ser_pend_if pif ();

   ser_msg_sender u_sender (
      .clk(clk),
      .rst(rst),
      .pif(pif.sender),
      .msg_valid(msg_valid),
      .msg_src(msg_src),
      .msg_ready(msg_ready)
   );

   // reporting needs agp mode and command bit 8; the enable register is written and read in any mode
   assign global_en = agp_mode && pci_command[SER_CMD_SERR_EN_BIT];
   assign en_hit = (cfg_addr == SER_EN_OFFSET);
   // each condition is gated by its own enable and the global one
   assign report = err_event & st.en[SER_NUM_SRC-1:0]
      & {SER_NUM_SRC{global_en}};

   assign pif.pend = st.pend;
   assign cfg_rdata = st.rdata;
   assign sts_sig_serr_set = st.sig_serr;
   assign sts_rcv_tabort_set = st.rcv_tabort;

   always_comb begin
      next_st = st;
      if (cfg_wr && en_hit) begin
         // upper two bits are not stored, so they can never read back
         next_st.en = {SER_RSVD_READ, cfg_wdata[SER_NUM_SRC-1:0]};
      end
      if (cfg_rd) begin
         next_st.rdata = en_hit ? {SER_RSVD_READ, st.en[5:0]} : 8'h00;
      end
      // a new occurrence in the clearing cycle stays pending: set wins
      next_st.pend = (st.pend & ~pif.clr) | report;
      next_st.sig_serr = |report;
      next_st.rcv_tabort = err_event[SER_BIT_TABORT];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '{en: SER_EN_RESET, pend: '0, rdata: 8'h00,
                 sig_serr: 1'b0, rcv_tabort: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   a_en_write: assert property (@(posedge clk) disable iff (rst)
      cfg_wr && en_hit |=> st.en[5:0] == $past(cfg_wdata[5:0]))
      else $error("enable bits did not take the written value");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      $past(cfg_rd) |-> cfg_rdata[7:6] == 2'h0)
      else $error("reserved enable bits read non-zero");
   a_rd_back: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && en_hit && !cfg_wr |=> cfg_rdata[5:0] == $past(st.en[5:0]))
      else $error("enable register read back wrong");
   a_global_gate: assert property (@(posedge clk) disable iff (rst)
      !global_en && st.pend == '0 |=> st.pend == '0)
      else $error("message pending while global enable is off");
   a_lock_off: assert property (@(posedge clk) disable iff (rst)
      !st.en[SER_BIT_LOCK] && !st.pend[SER_BIT_LOCK]
      |=> !st.pend[SER_BIT_LOCK])
      else $error("lock condition reported while disabled");
   a_lock_on: assert property (@(posedge clk) disable iff (rst)
      global_en && st.en[SER_BIT_LOCK] && err_event[SER_BIT_LOCK]
      |=> st.pend[SER_BIT_LOCK] && sts_sig_serr_set)
      else $error("lock to non-dram not reported");
   a_lock_cmd: assert property (@(posedge clk) disable iff (rst)
      sts_sig_serr_set |-> $past(pci_command[SER_CMD_SERR_EN_BIT]))
      else $error("signaled serr without global enable");
   a_tabort_sts: assert property (@(posedge clk) disable iff (rst)
      err_event[SER_BIT_TABORT] |=> sts_rcv_tabort_set)
      else $error("received target abort not flagged");
   a_msg_reach: assert property (@(posedge clk) disable iff (rst)
      report != '0 && !msg_valid && st.pend == '0 |=> ##1 msg_valid)
      else $error("reported error did not start a hub message");

   // register side: the stored byte and what the read port shows
   a_en_rsvd: assert property (@(posedge clk) disable iff (rst)
      st.en[7:6] == 2'h0)
      else $error("reserved enable bits were stored");
   a_en_keep: assert property (@(posedge clk) disable iff (rst)
      !(cfg_wr && en_hit) |=> $stable(st.en))
      else $error("enable bits changed without a write");
   a_rd_other: assert property (@(posedge clk) disable iff (rst)
      cfg_rd && !en_hit |=> cfg_rdata == 8'h00)
      else $error("other offset read non-zero");
   a_rd_hold: assert property (@(posedge clk) disable iff (rst)
      !cfg_rd |=> $stable(cfg_rdata))
      else $error("read data changed without a read");

   // status pulses follow only from what was taken on the previous edge
   a_sig_pulse: assert property (@(posedge clk) disable iff (rst)
      report != '0 |=> sts_sig_serr_set)
      else $error("reported error did not flag signaled serr");
   a_sig_only: assert property (@(posedge clk) disable iff (rst)
      !global_en |=> !sts_sig_serr_set)
      else $error("signaled serr flagged while globally disabled");
   a_agp_gate: assert property (@(posedge clk) disable iff (rst)
      !agp_mode |=> !sts_sig_serr_set)
      else $error("serr flagged outside agp mode");
   a_tabort_only: assert property (@(posedge clk) disable iff (rst)
      !err_event[SER_BIT_TABORT] |=> !sts_rcv_tabort_set)
      else $error("target abort flagged without an abort");

   // pending flags: set by a report, cleared only by a sent message
   a_pend_set: assert property (@(posedge clk) disable iff (rst)
      report != '0 |=> (st.pend & $past(report)) == $past(report))
      else $error("reported condition did not become pending");
   a_pend_rise: assert property (@(posedge clk) disable iff (rst)
      report == '0 |=> (st.pend & ~$past(st.pend)) == '0)
      else $error("condition pending without a report");
   a_pend_clear: assert property (@(posedge clk) disable iff (rst)
      pif.clr != '0 && report == '0
      |=> (st.pend & $past(pif.clr)) == '0)
      else $error("sent condition still pending");
   a_src_pend: assert property (@(posedge clk) disable iff (rst)
      msg_valid |-> msg_src <= 3'h5 && st.pend[msg_src])
      else $error("message names a condition that is not pending");

   // per condition: a disabled source never turns pending, none is lost
   for (genvar g = 0; g < SER_NUM_SRC; g++) begin : g_pend
      a_bit_gate: assert property (@(posedge clk) disable iff (rst)
         !st.en[g] && !st.pend[g] |=> !st.pend[g])
         else $error("disabled condition became pending");
      a_bit_keep: assert property (@(posedge clk) disable iff (rst)
         st.pend[g] && !pif.clr[g] |=> st.pend[g])
         else $error("pending condition lost before it was sent");
   end
endmodule // ser_top
`default_nettype wire

// ==== testbench/ser_hub_model.sv ====
// hub-side partner: takes system-error special cycles, promptly or slowly
`default_nettype none
module ser_hub_model (
   input wire logic clk,         // core clock
   input wire logic rst,         // synchronous reset
   input wire logic slow,        // stall each message three cycles
   input wire logic msg_valid,   // special-cycle request
   input wire logic [2:0] msg_src, // condition reported
   output logic msg_ready,       // message taken
   output int nmsg,              // messages taken since reset
   output logic [17:0] srcs      // sources taken, newest lowest
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_cnt;
   // only accept while a request stands; a stall tests request holding
   assign msg_ready = msg_valid && (!slow || wait_cnt == 3'h3);
   always @(posedge clk) begin
      if (rst) begin
         nmsg <= 0;
         srcs <= 18'h00000;
         wait_cnt <= 3'h0;
      end else if (msg_valid && msg_ready) begin
         nmsg <= nmsg + 1;
         srcs <= {srcs[14:0], msg_src};
         wait_cnt <= 3'h0;
      end else if (msg_valid) begin
         wait_cnt <= wait_cnt + 3'h1;
      end
   end
endmodule // ser_hub_model
`default_nettype wire

// ==== testbench/serr_error_report_enable_tb.sv ====
// testbench: enable register and system-error message gating
`default_nettype none
module serr_error_report_enable_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ser_pkg::*;
   logic clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, agp_mode = 0, slow = 0;
   logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
   logic [15:0] pci_command = 16'h0000;
   ser_vec_t err_event = '0;
   logic msg_valid, msg_ready, sts_sig_serr_set, sts_rcv_tabort_set;
   logic [2:0] msg_src;
   logic [17:0] srcs;
   int nmsg, nsig, ntab, errors, num_checks, cyc;
   ser_top i_ser_top (.clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
      .cfg_rdata, .agp_mode, .pci_command, .err_event, .msg_valid,
      .msg_src, .msg_ready, .sts_sig_serr_set, .sts_rcv_tabort_set);
   ser_hub_model i_ser_hub_model (.clk, .rst, .slow, .msg_valid, .msg_src,
      .msg_ready, .nmsg, .srcs);
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (sts_sig_serr_set === 1'b1) nsig++;
      if (sts_rcv_tabort_set === 1'b1) ntab++;
      if (cyc == 5000) begin
         errors++;
         complete_run();
      end
   end
   task complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input string what, input logic [17:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task cfg(input logic wr, input logic [7:0] a, d);
      @(posedge clk);
      cfg_wr <= wr;
      cfg_rd <= !wr;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 0;
      cfg_rd <= 0;
      #1;
   endtask
   // fresh reset each time so message history starts empty
   task fire(input ser_vec_t en, ev, input logic [15:0] cmd,
         input logic agp, input int n, input logic [17:0] s,
         input logic es, et);
      @(posedge clk) rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      cfg(1, SER_EN_OFFSET, {2'h3, en});
      @(posedge clk);
      pci_command <= cmd;
      agp_mode <= agp;
      @(posedge clk);
      nsig = 0;
      ntab = 0;
      err_event <= ev;
      @(posedge clk) err_event <= '0;
      repeat (40) @(posedge clk);
      #1;
      check("messages", 18'(n), 18'(nmsg));
      check("sources", s, srcs);
      check("status 14 set", 18'(es), 18'(nsig != 0));
      check("status 12 set", 18'(et), 18'(ntab != 0));
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      cfg(0, SER_EN_OFFSET, 8'h00);
      check("reset value", 18'(SER_EN_RESET), 18'(cfg_rdata));
      cfg(1, SER_EN_OFFSET, 8'hff);
      cfg(1, 8'hca, 8'h00);
      cfg(0, SER_EN_OFFSET, 8'h00);
      check("enables", 18'h0003f, 18'(cfg_rdata));
      cfg(0, 8'hca, 8'h00);
      check("other offset", 18'h00000, 18'(cfg_rdata));
      // only system-error reporting is switched on; no smi/sci path
      for (int i = 0; i < 6; i++) begin
         fire(ser_vec_t'(1 << i), 6'h3f, 16'h0100, 1, 1, 18'(i), 1, 1);
      end
      fire(6'h3f, 6'h3f, 16'hfeff, 1, 0, 18'h0, 0, 1);
      fire(6'h3f, 6'h2f, 16'h0100, 0, 0, 18'h0, 0, 0);
      fire(6'h37, 6'h08, 16'h0100, 1, 0, 18'h0, 0, 0);
      @(posedge clk) slow <= 1;
      fire(6'h3f, 6'h3f, 16'h0100, 1, 6, 18'h014e5, 1, 1);
      complete_run();
   end
endmodule // serr_error_report_enable_tb
`default_nettype wire
